// File: lfd_debounce.sv
// counter debounce filter for one synchronous input
`timescale 1ns/1ns
module lfd_debounce
	import lfd_pkg::*;
#(
	parameter int unsigned COUNT = DEBOUNCE_CYC
)
(
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	input  wire logic raw_in,
	output logic      stable_out
);
	logic [TMR_W-1:0] count;

	// any bounce back to the stable level restarts the wait
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			count      <= '0;
			stable_out <= 1'b0;
		end
		else if (ce_in)
		begin
			if (raw_in == stable_out)
				count <= '0; // RULE_26
			else if (count >= TMR_W'(COUNT - 1))
			begin
				count      <= '0;
				stable_out <= raw_in; // RULE_07
			end
			else
				count <= count + TMR_W'(1);
		end
	end
endmodule : lfd_debounce

// File: lfd_gamma_rom.sv
// two-port gamma level memory with registered read data
`timescale 1ns/1ns
module lfd_gamma_rom
	import lfd_pkg::*;
(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              ce_in,
	input  wire logic [STEP_W-1:0] addr_a_in,
	input  wire logic [STEP_W-1:0] addr_b_in,
	output logic [LVL_W-1:0]       data_a_out,
	output logic [LVL_W-1:0]       data_b_out
);
	function automatic logic [LVL_W-1:0] lookup(input logic [STEP_W-1:0] a);
		lookup = (a > STEP_LAST) ? GAMMA_TABLE[NUM_STEPS-1] : GAMMA_TABLE[a];
	endfunction : lookup

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			data_a_out <= '0;
			data_b_out <= '0;
		end
		else if (ce_in)
		begin
			data_a_out <= lookup(addr_a_in); // RULE_22
			data_b_out <= lookup(addr_b_in);
		end
	end
endmodule : lfd_gamma_rom

// File: lfd_pkg.sv
// constants, types and gamma table for the led fade/toggle dimmer
// Functional notes
// (RULE_01) switch type select: toggle high, level low
// (RULE_02) toggle mode: qualified low press turns on, fades up
// (RULE_03) toggle mode: press while on fades down, off
// (RULE_04) both main channels start off at zero
// (RULE_05) level mode: qualified high fades up when off
// (RULE_06) level mode: qualified low fades down when on
// (RULE_07) debounce both edges, one event per press
// (RULE_08) fades walk 63 gamma duty levels
// (RULE_09) new request mid fade reverses from present step
// (RULE_10) separate up and down fade durations
// (RULE_11) aux channel follows its enable, no fade
// (RULE_12) aux output turns on 6 us after enable
// (RULE_13) aux off while enable low; pwm on enable dims
// (RULE_14) dim source select: external high, internal low
// (RULE_15) polarity select picks active pwm level
// (RULE_16) external mode: channels follow pwm instantly
// (RULE_17) external pwm source runs 50 to 300 Hz
// (RULE_18) internal mode: debounced pwm change starts fade
// (RULE_19) internal 220 Hz pwm drives both channels
// (RULE_20) internal mode: active fades up, inactive down
// (RULE_21) pwm acts on both, enables on own channel
// (RULE_22) levels follow fixed gamma table 0 to 1000
// (RULE_23) ramp input zero gives about 70 us fade
// (RULE_24) supply loss reset clears toggle latches to off
// (RULE_25) active pwm request beats enable requests
// (RULE_26) debounce counter needs full stable count
package lfd_pkg;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned DEBOUNCE_MS   = 37;
	localparam int unsigned DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned AUX_DELAY_US  = 6;
	localparam int unsigned AUX_DELAY_CYC = CLK_HZ / 1_000_000 * AUX_DELAY_US;
	localparam int unsigned FAST_FADE_US  = 70;
	localparam int unsigned FAST_FADE_CYC = CLK_HZ / 1_000_000 * FAST_FADE_US;
	localparam int unsigned RAMP_UNIT_MS  = 1;
	localparam int unsigned RAMP_UNIT_CYC = CLK_HZ / 1000 * RAMP_UNIT_MS;
	localparam int unsigned PWM_HZ        = 220;
	localparam int unsigned GAMMA_FULL    = 1000;
	localparam int unsigned PWM_TICK_CYC  = CLK_HZ / (PWM_HZ * GAMMA_FULL);
	localparam int unsigned NUM_STEPS     = 63;
	localparam int unsigned STEP_W        = 6;
	localparam int unsigned LVL_W         = 10;
	localparam int unsigned RAMP_W        = 8;
	localparam int unsigned TMR_W         = 32;
	localparam logic [STEP_W-1:0] STEP_ZERO = 6'h00;
	localparam logic [STEP_W-1:0] STEP_LAST = 6'h3e;
	localparam logic [LVL_W-1:0]  PHASE_LAST = 10'h3e7;

	typedef enum logic [1:0] {
		LFD_OFF  = 2'h0,
		LFD_RISE = 2'h1,
		LFD_ON   = 2'h3,
		LFD_FALL = 2'h2
	} lfd_state_t;

	typedef struct packed {
		lfd_state_t         state;
		logic [STEP_W-1:0]  step;
		logic [TMR_W-1:0]   timer;
	} lfd_chan_t;

	typedef struct packed {
		logic ext_dim;
		logic toggle_mode;
		logic pol_high;
	} lfd_cfg_t;

	localparam logic [LVL_W-1:0] GAMMA_TABLE [0:NUM_STEPS-1] = '{
		10'd0,   10'd2,   10'd4,   10'd6,   10'd8,   10'd10,  10'd12,  10'd16,
		10'd20,  10'd24,  10'd28,  10'd32,  10'd36,  10'd42,  10'd48,  10'd54,
		10'd60,  10'd66,  10'd72,  10'd80,  10'd88,  10'd96,  10'd104, 10'd112,
		10'd120, 10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180, 10'd194,
		10'd208, 10'd222, 10'd236, 10'd250, 10'd264, 10'd282, 10'd300, 10'd318,
		10'd336, 10'd354, 10'd372, 10'd394, 10'd416, 10'd438, 10'd460, 10'd482,
		10'd504, 10'd534, 10'd564, 10'd594, 10'd624, 10'd654, 10'd684, 10'd722,
		10'd760, 10'd798, 10'd836, 10'd874, 10'd914, 10'd956, 10'd1000
	};
endpackage : lfd_pkg

// File: lfd_props.sv
// assertions on the dimmer top ports
`timescale 1ns/1ns
module lfd_props
	import lfd_pkg::*;
(
	input wire logic       clock_in,
	input wire logic       rst_in,
	input wire logic       ce_in,
	input wire logic [1:0] main_channel_toggle_inputs_in,
	input wire logic       aux_channel_enable_input_in,
	input wire logic       pwm_input_in,
	input wire logic       dim_source_select_in,
	input wire logic       switch_type_select_in,
	input wire logic       pwm_polarity_select_in,
	input wire logic [1:0] main_led_outputs_out,
	input wire logic       aux_led_output_out,
	input wire logic [1:0] channel_on_out,
	input wire logic [1:0] fade_busy_out
);
	logic [9:0] aux_cnt;
	logic [1:0] warm;
	logic       ext;
	logic       lvl;
	logic       tgl;
	// straps are only trusted once sampled after reset
	assign ext = dim_source_select_in & warm[1];
	assign lvl = ext & ~switch_type_select_in;
	assign tgl = ext & switch_type_select_in;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);
	// aux qualify count, saturates at the on threshold
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			aux_cnt <= 10'h000;
		else if (ce_in && !aux_channel_enable_input_in)
			aux_cnt <= 10'h000;
		else if (ce_in && aux_cnt != 10'h258)
			aux_cnt <= aux_cnt + 10'h001;
	end
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			warm <= 2'h0;
		else if (!warm[1])
			warm <= warm + 2'h1;
	end
	a_reset_dark: assert property (disable iff (1'b0)
		rst_in |=> {main_led_outputs_out, aux_led_output_out,
		channel_on_out, fade_busy_out} == 7'h00)
		else $error("outputs not cleared");
	a_aux_delay: assert property (
		aux_led_output_out == (aux_cnt == 10'h258))
		else $error("aux timing off");
	a_ext_pwm_on: assert property (
		(ext && pwm_input_in == pwm_polarity_select_in)[*3]
		|=> main_led_outputs_out == 2'b11)
		else $error("external pwm not followed");
	a_dark_off: assert property (
		(!dim_source_select_in && !channel_on_out[0]
		&& !fade_busy_out[0])[*4] |=> !main_led_outputs_out[0])
		else $error("dark channel lit");
	a_full_on: assert property (
		(channel_on_out[1] && !fade_busy_out[1])[*4]
		|=> main_led_outputs_out[1])
		else $error("full channel dark");
	a_toggle_rise: assert property (
		(tgl && main_channel_toggle_inputs_in[0])[*5]
		##0 (!channel_on_out[0] && !fade_busy_out[0]) |=> !channel_on_out[0])
		else $error("release toggled channel");
	a_level_hold_on: assert property (
		(lvl && main_channel_toggle_inputs_in[1])[*5]
		##0 (channel_on_out[1] && !fade_busy_out[1]) |=> channel_on_out[1])
		else $error("level high dropped channel");
	a_level_hold_off: assert property (
		(lvl && !main_channel_toggle_inputs_in[1])[*5]
		##0 (!channel_on_out[1] && !fade_busy_out[1]) |=> !channel_on_out[1])
		else $error("level low lit channel");
	c_both_fade: cover property (fade_busy_out == 2'b11);
	c_aux_on: cover property ($rose(aux_led_output_out));
	c_reverse: cover property (channel_on_out[1] ##1 !channel_on_out[1]);
endmodule : lfd_props
bind lfd_top lfd_props u_props (
	.clock_in, .rst_in, .ce_in, .main_channel_toggle_inputs_in,
	.aux_channel_enable_input_in, .pwm_input_in, .dim_source_select_in,
	.switch_type_select_in, .pwm_polarity_select_in, .main_led_outputs_out,
	.aux_led_output_out, .channel_on_out, .fade_busy_out
);

// File: lfd_switch_model.sv
// switch pair model: contacts chatter before settling
`timescale 1ns/1ns
module lfd_switch_model (
	input  wire logic       clock_in,
	input  wire logic [1:0] contact_in,
	output logic [1:0]      pin_out
);
	logic [1:0] last = 2'b11;
	int         chat [2] = '{0, 0};
	initial
		pin_out = 2'b11;
	// chatter stays under the filter count: one press, one event
	always @(negedge clock_in)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (contact_in[i] !== last[i])
				chat[i] = 3;
			pin_out[i] = chat[i] > 0 ? ~pin_out[i] : contact_in[i];
			if (chat[i] > 0)
				chat[i]--;
			last[i] = contact_in[i];
		end
	end
endmodule : lfd_switch_model

// File: lfd_top.sv
// led fade/toggle dimmer control: two faded channels, one aux
`timescale 1ns/1ns
module lfd_top
	import lfd_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_CYC,
	parameter int unsigned FAST_FADE_CYCLES = FAST_FADE_CYC,
	parameter int unsigned RAMP_UNIT_CYCLES = RAMP_UNIT_CYC
)
(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              ce_in,
	input  wire logic [1:0]        main_channel_toggle_inputs_in,
	input  wire logic              aux_channel_enable_input_in,
	input  wire logic              pwm_input_in,
	input  wire logic              dim_source_select_in,
	input  wire logic              switch_type_select_in,
	input  wire logic              pwm_polarity_select_in,
	input  wire logic [RAMP_W-1:0] ramp_up_time_input_in,
	input  wire logic [RAMP_W-1:0] ramp_down_time_input_in,
	output logic [1:0]             main_led_outputs_out,
	output logic                   aux_led_output_out,
	output logic [1:0]             channel_on_out,
	output logic [1:0]             fade_busy_out
);
	lfd_cfg_t          cfg;
	lfd_chan_t         chan [0:1];
	logic [1:0]        en_deb;
	logic [1:0]        en_prev;
	logic              pwm_deb;
	logic              pwm_deb_prev;
	logic              pwm_act_deb;
	logic              pwm_act_raw;
	logic              pwm_on_evt;
	logic              pwm_off_evt;
	logic [1:0]        on_req;
	logic [1:0]        off_req;
	logic [1:0]        tog_req;
	logic [1:0]        go_up;
	logic [1:0]        go_dn;
	logic [TMR_W-1:0]  up_period;
	logic [TMR_W-1:0]  dn_period;
	logic [LVL_W-1:0]  level [0:1];
	logic [LVL_W-1:0]  phase;
	logic [TMR_W-1:0]  tick_cnt;
	logic [TMR_W-1:0]  aux_cnt;

	// cycles per gamma step; a grounded ramp input means near instant
	function automatic logic [TMR_W-1:0] step_period(
		input logic [RAMP_W-1:0] t
	);
		logic [63:0] full;
		full = (t == '0) ? 64'(FAST_FADE_CYCLES) // RULE_23
		                 : 64'(t) * 64'(RAMP_UNIT_CYCLES);
		full = full / 64'(NUM_STEPS - 1);
		step_period = (full == 64'h0) ? TMR_W'(1) : full[TMR_W-1:0];
	endfunction : step_period

	function automatic logic is_lit(input lfd_state_t s);
		is_lit = (s == LFD_ON) || (s == LFD_RISE);
	endfunction : is_lit

	// mode straps are static, so one register stage is plenty
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			cfg <= '0;
		else if (ce_in)
		begin
			cfg.ext_dim     <= dim_source_select_in; // RULE_14
			cfg.toggle_mode <= switch_type_select_in; // RULE_01
			cfg.pol_high    <= pwm_polarity_select_in; // RULE_15
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			up_period <= TMR_W'(1);
			dn_period <= TMR_W'(1);
		end
		else if (ce_in)
		begin
			up_period <= step_period(ramp_up_time_input_in); // RULE_10
			dn_period <= step_period(ramp_down_time_input_in);
		end
	end

	for (genvar g = 0; g < 2; g++)
	begin : g_en_deb
		lfd_debounce #(
			.COUNT      (DEBOUNCE_CYCLES)
		) u_en_deb (
			.clock_in   (clock_in),
			.rst_in     (rst_in),
			.ce_in      (ce_in),
			.raw_in     (main_channel_toggle_inputs_in[g]),
			.stable_out (en_deb[g])
		);
	end

	lfd_debounce #(
		.COUNT      (DEBOUNCE_CYCLES)
	) u_pwm_deb (
		.clock_in   (clock_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.raw_in     (pwm_input_in),
		.stable_out (pwm_deb)
	);

	assign pwm_act_deb = cfg.pol_high ? pwm_deb : ~pwm_deb; // RULE_15
	assign pwm_act_raw = cfg.pol_high ? pwm_input_in : ~pwm_input_in;

	// edge history resets like the filters, so release gives no event
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			en_prev      <= 2'h0;
			pwm_deb_prev <= 1'b0;
		end
		else if (ce_in)
		begin
			en_prev      <= en_deb;
			pwm_deb_prev <= pwm_deb;
		end
	end

	always_comb
	begin
		pwm_on_evt  = 1'b0;
		pwm_off_evt = 1'b0;
		if (!cfg.ext_dim)
		begin
			// polarity applied after the edge: a strap load is no event
			pwm_on_evt  = (pwm_deb ^ pwm_deb_prev) & pwm_act_deb; // RULE_18
			pwm_off_evt = (pwm_deb ^ pwm_deb_prev) & ~pwm_act_deb;
		end
	end

	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			on_req[c]  = 1'b0;
			off_req[c] = 1'b0;
			tog_req[c] = 1'b0;
			if (cfg.toggle_mode)
				tog_req[c] = ~en_deb[c] & en_prev[c]; // RULE_02
			else
			begin
				on_req[c]  = en_deb[c] & ~en_prev[c]; // RULE_05
				off_req[c] = ~en_deb[c] & en_prev[c]; // RULE_06
			end
			// one pwm event lands on both channels and wins
			if (pwm_on_evt || pwm_off_evt)
			begin
				on_req[c]  = pwm_on_evt; // RULE_25
				off_req[c] = pwm_off_evt; // RULE_21
				tog_req[c] = 1'b0;
			end
		end
	end

	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			go_up[c] = 1'b0;
			go_dn[c] = 1'b0;
			if (tog_req[c])
			begin
				go_dn[c] = is_lit(chan[c].state); // RULE_03
				go_up[c] = ~is_lit(chan[c].state); // RULE_02
			end
			else if (on_req[c])
				go_up[c] = ~is_lit(chan[c].state); // RULE_20
			else if (off_req[c])
				go_dn[c] = is_lit(chan[c].state); // RULE_20
		end
	end

	// fade engine; a reversal keeps the step so the light never jumps
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			for (int c = 0; c < 2; c++)
			begin
				chan[c].state <= LFD_OFF; // RULE_04
				chan[c].step  <= STEP_ZERO; // RULE_24
				chan[c].timer <= '0;
			end
		end
		else if (ce_in)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (go_up[c])
				begin
					chan[c].state <= LFD_RISE; // RULE_09
					chan[c].timer <= '0;
				end
				else if (go_dn[c])
				begin
					chan[c].state <= LFD_FALL; // RULE_09
					chan[c].timer <= '0;
				end
				else
				begin
					case (chan[c].state)
						LFD_RISE:
						begin
							if (chan[c].timer >= up_period - TMR_W'(1))
							begin
								chan[c].timer <= '0;
								if (chan[c].step >= STEP_LAST)
									chan[c].state <= LFD_ON;
								else
									chan[c].step <= chan[c].step + 6'h01; // RULE_08
							end
							else
								chan[c].timer <= chan[c].timer + TMR_W'(1);
						end
						LFD_FALL:
						begin
							if (chan[c].timer >= dn_period - TMR_W'(1))
							begin
								chan[c].timer <= '0;
								if (chan[c].step == STEP_ZERO)
									chan[c].state <= LFD_OFF;
								else
									chan[c].step <= chan[c].step - 6'h01; // RULE_08
							end
							else
								chan[c].timer <= chan[c].timer + TMR_W'(1);
						end
						LFD_ON:
						begin
							chan[c].timer <= '0;
							chan[c].step  <= STEP_LAST;
						end
						default:
						begin
							chan[c].state <= LFD_OFF;
							chan[c].timer <= '0;
							chan[c].step  <= STEP_ZERO;
						end
					endcase
				end
			end
		end
	end

	lfd_gamma_rom u_rom (
		.clock_in   (clock_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.addr_a_in  (chan[0].step),
		.addr_b_in  (chan[1].step),
		.data_a_out (level[0]),
		.data_b_out (level[1])
	);

	// one shared 220 Hz frame split into 1000 duty slots
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			tick_cnt <= '0;
			phase    <= '0;
		end
		else if (ce_in)
		begin
			if (tick_cnt >= TMR_W'(PWM_TICK_CYC - 1))
			begin
				tick_cnt <= '0;
				if (phase >= PHASE_LAST)
					phase <= '0; // RULE_19
				else
					phase <= phase + 10'h001;
			end
			else
				tick_cnt <= tick_cnt + TMR_W'(1);
		end
	end

	// external mode: an active raw pin forces both outputs on unfiltered, else the gamma pwm drives them
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			main_led_outputs_out <= 2'h0;
		else if (ce_in)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (cfg.ext_dim && pwm_act_raw)
					main_led_outputs_out[c] <= 1'b1; // RULE_16
				else
					main_led_outputs_out[c] <= level[c] > phase; // RULE_19
			end
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			channel_on_out <= 2'h0;
			fade_busy_out  <= 2'h0;
		end
		else if (ce_in)
		begin
			for (int c = 0; c < 2; c++)
			begin
				channel_on_out[c] <= is_lit(chan[c].state);
				fade_busy_out[c]  <= (chan[c].state == LFD_RISE) ||
				                     (chan[c].state == LFD_FALL);
			end
		end
	end

	// aux path: short turn-on delay, immediate turn-off, so a pwm on
	// the enable still dims it by duty cycle
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			aux_cnt            <= '0;
			aux_led_output_out <= 1'b0;
		end
		else if (ce_in)
		begin
			if (!aux_channel_enable_input_in)
			begin
				aux_cnt            <= '0;
				aux_led_output_out <= 1'b0; // RULE_13
			end
			else if (aux_cnt >= TMR_W'(AUX_DELAY_CYC - 1))
				aux_led_output_out <= 1'b1; // RULE_12
			else
				aux_cnt <= aux_cnt + TMR_W'(1); // RULE_11
		end
	end
endmodule : lfd_top

// File: test_lfd_top.sv
// self-checking bench for the dimmer top
`timescale 1ns/1ns
module test_lfd_top
	import lfd_pkg::*;
;
	localparam int D = 8;
	logic        clock_in;
	logic        rst_in;
	logic        ce;
	logic        pwm;
	logic        aux_en;
	logic [1:0]  contact;
	logic [1:0]  pins;
	logic [7:0]  t_up;
	logic [7:0]  t_dn;
	lfd_cfg_t    cfg;
	logic [1:0]  main_out;
	logic        aux_out;
	logic [1:0]  on;
	logic [1:0]  busy;
	logic [4:0]  w;
	logic [4:0]  cur = 5'h00;
	logic [4:0]  prev = 5'h00;
	logic [4:0]  expq [$];
	logic [31:0] rnd = 32'h9bfa;
	int          failures = 0;
	int          checks = 0;
	int          cyc = 0;
	int          n;
	assign w = {aux_out, busy, on};
	initial
	begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	lfd_top #(
		.DEBOUNCE_CYCLES(D),
		.FAST_FADE_CYCLES(124),
		.RAMP_UNIT_CYCLES(62)
	) dut (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.ce_in(ce),
		.main_channel_toggle_inputs_in(pins),
		.aux_channel_enable_input_in(aux_en),
		.pwm_input_in(pwm),
		.dim_source_select_in(cfg.ext_dim),
		.switch_type_select_in(cfg.toggle_mode),
		.pwm_polarity_select_in(cfg.pol_high),
		.ramp_up_time_input_in(t_up),
		.ramp_down_time_input_in(t_dn),
		.main_led_outputs_out(main_out),
		.aux_led_output_out(aux_out),
		.channel_on_out(on),
		.fade_busy_out(busy)
	);
	lfd_switch_model sw (
		.clock_in(clock_in),
		.contact_in(contact),
		.pin_out(pins)
	);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic results();
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	task automatic cycles(input int k);
		repeat (k) @(negedge clock_in);
	endtask : cycles
	task automatic note(input logic [4:0] v);
		cur = v;
		expq.push_back(v);
	endtask : note
	// straps only change under reset
	task automatic restart(input lfd_cfg_t c, input logic [1:0] k);
		cfg = c;
		contact <= k;
		aux_en = 1'b0;
		rst_in = 1'b1;
		if (cur != 5'h00)
			note(5'h00);
		cycles(10);
		rst_in = 1'b0;
		cycles(D + 6);
	endtask : restart
	task automatic rise(input int ch, input logic [1:0] k);
		n = 0;
		while (busy[ch] !== 1'b1 && n < D + 20)
		begin
			cycles(1);
			n++;
		end
		contact <= k;
	endtask : rise
	task automatic fall_len(input int ch, input int lo, input int hi);
		n = 0;
		while (busy[ch] !== 1'b0 && n < 20000)
		begin
			cycles(1);
			n++;
		end
		check(n >= lo && n <= hi, 1'b1);
	endtask : fall_len
	always @(negedge clock_in)
	begin
		if (w !== prev)
		begin
			if (expq.size() == 0)
				check(w, prev);
			else
				check(w, expq.pop_front());
			prev = w;
		end
	end
	always @(posedge clock_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			results();
		end
	end
	initial
	begin
		ce = 1'b1;
		pwm = 1'b0;
		t_up = 8'h0a;
		t_dn = 8'h05;
		restart(3'b011, 2'b11);
		check(main_out, 2'h0);
		note(5'h05);
		note(5'h01);
		contact[0] <= 1'b0;
		rise(0, 2'b11);
		fall_len(0, 628, 636);
		note(5'h04);
		note(5'h00);
		contact[0] <= 1'b0;
		rise(0, 2'b11);
		fall_len(0, 313, 317);
		contact[0] <= 1'b0;
		cycles(4);
		contact[0] <= 1'b1;
		cycles(D + 10);
		note(5'h0a);
		note(5'h08);
		note(5'h00);
		contact[1] <= 1'b0;
		rise(1, 2'b11);
		cycles(200);
		contact[1] <= 1'b0;
		cycles(D + 8);
		contact[1] <= 1'b1;
		fall_len(1, 60, 200);
		t_up = 8'h00;
		restart(3'b011, 2'b11);
		note(5'h05);
		note(5'h01);
		contact[0] <= 1'b0;
		rise(0, 2'b11);
		fall_len(0, 122, 130);
		t_up = 8'h0a;
		restart(3'b101, 2'b00);
		note(5'h0a);
		note(5'h02);
		contact[1] <= 1'b1;
		rise(1, 2'b10);
		fall_len(1, 628, 636);
		cycles(20);
		note(5'h08);
		note(5'h00);
		contact[1] <= 1'b0;
		rise(1, 2'b00);
		fall_len(1, 313, 317);
		for (int p = 0; p < 2; p++)
		begin
			restart(p[2:0] | 3'b110, 2'b11);
			repeat (16)
			begin
				rnd = lfsr(rnd);
				pwm = rnd[0];
				cycles(3);
				check(main_out, {2{rnd[0] == p[0]}});
			end
		end
		pwm = 1'b1;
		restart(3'b010, 2'b11);
		note(5'h0f);
		note(5'h03);
		pwm = 1'b0;
		rise(0, 2'b11);
		fall_len(0, 628, 636);
		note(5'h0c);
		note(5'h00);
		pwm = 1'b1;
		rise(0, 2'b11);
		fall_len(0, 313, 317);
		repeat (4)
		begin
			rnd = lfsr(rnd);
			aux_en = 1'b1;
			cycles(rnd[7:0] + 1);
			aux_en = 1'b0;
			cycles(2);
		end
		note(5'h10);
		aux_en = 1'b1;
		// a low clock enable must stretch the aux delay
		ce = 1'b0;
		cycles(5);
		ce = 1'b1;
		n = 5;
		while (aux_out !== 1'b1 && n < 700)
		begin
			cycles(1);
			n++;
		end
		check(n, 605);
		note(5'h00);
		aux_en = 1'b0;
		cycles(3);
		check(expq.size(), 0);
		results();
	end
endmodule : test_lfd_top
